// *** lfsch_params.svh ***
// Purpose: constants of the host command handler
// Assumes: 125 MHz clock
// Notes:   codes, limits, reset values and timing counts
`ifndef LFSCH_PARAMS_SVH
`define LFSCH_PARAMS_SVH
`define LFS_ACK_BITS     8'h40
`define LFS_ERR_BITS     8'hC0
`define LFS_CMD_LCDRD    8'h0A
`define LFS_CMD_CURPOS   8'h0B
`define LFS_CMD_CURSTY   8'h0C
`define LFS_CMD_CONTRAST 8'h0D
`define LFS_CMD_BKLIGHT  8'h0E
`define LFS_CMD_FANRPT   8'h10
`define LFS_CMD_FANPWR   8'h11
`define LFS_CMD_INFO     8'h12
`define LFS_CMD_TEMPRPT  8'h13
`define LFS_CMD_BUSTX    8'h14
`define LFS_COLS         8'h10
`define LFS_ROWS         8'h02
`define LFS_STYLES       8'h04
`define LFS_CONTRAST_MAX 8'h32
`define LFS_PWR_MAX      8'h64
`define LFS_FANMASK_MAX  8'h0F
`define LFS_IDX_MAX      8'h1F
`define LFS_IDX_SKIP     8'h20
`define LFS_RD_MAX       8'h10
`define LFS_MATCH_CMD    8'h55
`define LFS_ADDR_BYTES   6'h09
`define LFS_DATA_LEN     5'h09
`define LFS_RST_CONTRAST 8'h10
`define LFS_RST_BKLIGHT  8'h64
`define LFS_RST_FANPWR   8'h64
`define LFS_CLK_NS       8
`define LFS_EIGHTH_NS    125000000
`endif

// *** lfsch_pkg.sv ***
// Purpose: types of the host command handler
// Assumes: nothing
// Notes:   packets carry up to 16 data bytes
package lfsch_pkg;
   typedef logic [15:0][7:0] lfsch_bytes_t;
   typedef struct packed {
      logic [7:0]   typ;
      logic [4:0]   len;
      lfsch_bytes_t data;
   } lfsch_pkt_s;
   typedef struct packed {
      logic [3:0]      col;
      logic            row;
      logic [1:0]      style;
      logic [7:0]      contrast;
      logic [7:0]      backlight;
      logic [3:0][7:0] fan_pwr;
   } lfsch_set_s;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, ST_LCD = 5'h02, ST_ISSUE = 5'h04, ST_BUS = 5'h08, ST_RSP = 5'h10
   } lfsch_state_e;
   typedef enum logic [1:0] {OP_RESET = 2'h0, OP_WRITE = 2'h1, OP_READ = 2'h2} lfsch_op_e;
endpackage

// *** lfsch_top.sv ***
// Purpose: command handler for display, fan and sensor bus commands
// Assumes: framing and checksum are done outside; one request at a time
// Notes:   bus byte engine and LCD reader are outside, reached by handshakes
`timescale 1ns/10ps
`include "lfsch_params.svh"
module lfsch_top import lfsch_pkg::*; #(
   parameter int EIGHTH_CYC = `LFS_EIGHTH_NS / `LFS_CLK_NS
) (
   input  wire logic             I_CLK,
   input  wire logic             I_RST,
   input  wire logic             I_REQ_VALID,
   input  wire lfsch_pkt_s       I_REQ,
   output logic                  O_REQ_READY,
   output logic                  O_RSP_VALID,
   output lfsch_pkt_s            O_RSP,
   input  wire logic             I_RSP_READY,
   output logic                  O_LCD_RD_VALID,
   output logic [7:0]            O_LCD_ADDR,
   input  wire logic             I_LCD_RD_DONE,
   input  wire logic [7:0][7:0]  I_LCD_RD_DATA,
   output logic                  O_BUS_OP_VALID,
   output lfsch_op_e             O_BUS_OP,
   output logic [7:0]            O_BUS_WDATA,
   input  wire logic             I_BUS_DONE,
   input  wire logic [7:0]       I_BUS_RDATA,
   output logic                  O_ENUM_START,
   input  wire logic             I_ENUM_VALID,
   input  wire logic [4:0]       I_ENUM_IDX,
   input  wire logic [7:0][7:0]  I_ENUM_CODE,
   output lfsch_set_s            O_SET,
   output logic [3:0][7:0]       O_FAN_PWR,
   input  wire logic             I_SAVE_REQ,
   output lfsch_set_s            O_BOOT_SET,
   output logic                  O_FAN_RPT,
   output logic [1:0]            O_FAN_RPT_IDX,
   output logic                  O_TEMP_RPT,
   output logic [31:0]           O_TEMP_MASK
);
   lfsch_state_e         st_q, st_d;
   lfsch_pkt_s           rsp_q, rsp_d, req_q, req_d;
   lfsch_set_s           set_q, set_d, boot_q, boot_d;
   lfsch_op_e            op_q, op_d;
   logic [3:0]           fm_q, fm_d;
   logic [31:0]          tm_q, tm_d;
   logic [7:0]           wd_q, wd_d;
   logic [5:0]           cnt_q, cnt_d, wtot_q, wtot_d, k, off;
   logic                 adr_q, adr_d, ok;
   logic [31:0][7:0][7:0] id_q, id_d;
   logic [31:0]          pres_q, pres_d;
   logic                 up_q, up_d, es_q, es_d;
   logic [23:0]          ecnt_q, ecnt_d;
   logic [2:0]           slot_q, slot_d;
   logic                 fr_q, fr_d, tr_q, tr_d, tick;
   logic [7:0]           d0, d1;
   logic [4:0]           rdn;

   // Command decode, settings and bus transaction sequencing
   always_comb begin
      st_d = st_q; rsp_d = rsp_q; req_d = req_q; set_d = set_q;
      fm_d = fm_q; tm_d = tm_q; op_d = op_q; wd_d = wd_q;
      cnt_d = cnt_q; wtot_d = wtot_q; adr_d = adr_q; ok = 1'b0;
      d0 = I_REQ.data[0]; d1 = I_REQ.data[1];
      rdn = req_q.data[1][4:0];
      k = cnt_q - 6'h01;
      off = adr_q ? `LFS_ADDR_BYTES : 6'h00;
      case (st_q)
         ST_IDLE: if (I_REQ_VALID) begin
            req_d = I_REQ;
            rsp_d = '0;
            rsp_d.typ = I_REQ.typ | `LFS_ACK_BITS;
            case (I_REQ.typ)
               `LFS_CMD_LCDRD: if (I_REQ.len == 5'h01) begin
                  ok = 1'b1; st_d = ST_LCD;
               end
               `LFS_CMD_CURPOS: if (I_REQ.len == 5'h02 && d0 < `LFS_COLS && d1 < `LFS_ROWS) begin
                  ok = 1'b1; set_d.col = d0[3:0]; set_d.row = d1[0];
               end
               `LFS_CMD_CURSTY: if (I_REQ.len == 5'h01 && d0 < `LFS_STYLES) begin
                  ok = 1'b1; set_d.style = d0[1:0];
               end
               `LFS_CMD_CONTRAST: if (I_REQ.len == 5'h01 && d0 <= `LFS_CONTRAST_MAX) begin
                  ok = 1'b1; set_d.contrast = d0;
               end
               `LFS_CMD_BKLIGHT: if (I_REQ.len == 5'h01 && d0 <= `LFS_PWR_MAX) begin
                  ok = 1'b1; set_d.backlight = d0;
               end
               `LFS_CMD_FANRPT: if (I_REQ.len == 5'h01 && d0 <= `LFS_FANMASK_MAX) begin
                  ok = 1'b1; fm_d = d0[3:0];
               end
               `LFS_CMD_FANPWR: if (I_REQ.len == 5'h04 && I_REQ.data[0] <= `LFS_PWR_MAX
                     && I_REQ.data[1] <= `LFS_PWR_MAX && I_REQ.data[2] <= `LFS_PWR_MAX
                     && I_REQ.data[3] <= `LFS_PWR_MAX) begin
                  ok = 1'b1; set_d.fan_pwr = I_REQ.data[3:0];
               end
               `LFS_CMD_INFO: if (I_REQ.len == 5'h01 && d0 <= `LFS_IDX_MAX) begin
                  ok = 1'b1; rsp_d.len = `LFS_DATA_LEN;
                  rsp_d.data[0] = d0;
                  rsp_d.data[8:1] = id_q[d0[4:0]];
               end
               `LFS_CMD_TEMPRPT: if (I_REQ.len == 5'h04) begin
                  ok = 1'b1; tm_d = I_REQ.data[3:0];
               end
               `LFS_CMD_BUSTX: if (I_REQ.len >= 5'h02 && I_REQ.len <= 5'h10
                     && d1 <= `LFS_RD_MAX && (d0 == `LFS_IDX_SKIP
                     || (d0 <= `LFS_IDX_MAX && pres_q[d0[4:0]]))) begin
                  ok = 1'b1; st_d = ST_ISSUE; cnt_d = 6'h00;
                  adr_d = (d0 != `LFS_IDX_SKIP);
                  wtot_d = (d0 != `LFS_IDX_SKIP ? `LFS_ADDR_BYTES : 6'h00)
                         + {1'b0, I_REQ.len} - 6'h02;
               end
               default: ;
            endcase
            // A refused request leaves every setting as it was
            if (!ok) begin
               rsp_d.typ = I_REQ.typ | `LFS_ERR_BITS;
               set_d = set_q; fm_d = fm_q; tm_d = tm_q; st_d = ST_RSP;
            end else if (st_d == ST_IDLE) begin
               st_d = ST_RSP;
            end
         end
         ST_LCD: if (I_LCD_RD_DONE) begin
            rsp_d.len = `LFS_DATA_LEN;
            rsp_d.data[0] = req_q.data[0];
            rsp_d.data[8:1] = I_LCD_RD_DATA;
            st_d = ST_RSP;
         end
         // One bus step: reset, then address and payload writes, then reads
         ST_ISSUE: begin
            if (cnt_q > wtot_q + {1'b0, rdn}) begin
               rsp_d.len = rdn;
               st_d = ST_RSP;
            end else begin
               st_d = ST_BUS;
               wd_d = 8'h00;
               if (cnt_q == 6'h00) begin
                  op_d = OP_RESET;
               end else if (cnt_q <= wtot_q) begin
                  op_d = OP_WRITE;
                  if (adr_q && k == 6'h00) begin
                     wd_d = `LFS_MATCH_CMD;
                  end else if (adr_q && k < `LFS_ADDR_BYTES) begin
                     wd_d = id_q[req_q.data[0][4:0]][3'(k - 6'h01)];
                  end else begin
                     wd_d = req_q.data[4'(k - off + 6'h02)];
                  end
               end else begin
                  op_d = OP_READ;
               end
            end
         end
         ST_BUS: if (I_BUS_DONE) begin
            if (op_q == OP_READ) begin
               rsp_d.data[4'(cnt_q - wtot_q - 6'h01)] = I_BUS_RDATA;
            end
            cnt_d = cnt_q + 6'h01;
            st_d = ST_ISSUE;
         end
         ST_RSP: if (I_RSP_READY) begin
            st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         st_q <= ST_IDLE; rsp_q <= '0; req_q <= '0; fm_q <= 4'h0; tm_q <= 32'h0000_0000;
         set_q <= '{col: 4'h0, row: 1'b0, style: 2'h0, contrast: `LFS_RST_CONTRAST,
                    backlight: `LFS_RST_BKLIGHT, fan_pwr: {4{`LFS_RST_FANPWR}}};
         op_q <= OP_RESET; wd_q <= 8'h00; cnt_q <= 6'h00; wtot_q <= 6'h00; adr_q <= 1'b0;
      end else begin
         st_q <= st_d; rsp_q <= rsp_d; req_q <= req_d; fm_q <= fm_d; tm_q <= tm_d;
         set_q <= set_d; op_q <= op_d; wd_q <= wd_d; cnt_q <= cnt_d;
         wtot_q <= wtot_d; adr_q <= adr_d;
      end
   end

   // Identity table, boot snapshot and one start pulse after reset
   always_comb begin
      id_d = id_q; pres_d = pres_q;
      if (I_ENUM_VALID) begin
         id_d[I_ENUM_IDX] = I_ENUM_CODE;
         pres_d[I_ENUM_IDX] = 1'b1;
      end
      boot_d = I_SAVE_REQ ? set_q : boot_q;
      up_d = 1'b1;
      es_d = !up_q;
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         id_q <= '0; pres_q <= 32'h0000_0000; boot_q <= '0; up_q <= 1'b0; es_q <= 1'b0;
      end else begin
         id_q <= id_d; pres_q <= pres_d; boot_q <= boot_d; up_q <= up_d; es_q <= es_d;
      end
   end

   // Eighth-second slots: four per half second, eight per second
   always_comb begin
      tick = (ecnt_q == 24'(EIGHTH_CYC - 1));
      ecnt_d = tick ? 24'h00_0000 : ecnt_q + 24'h00_0001;
      slot_d = tick ? slot_q + 3'h1 : slot_q;
      // Mask as it stands after this edge, so a report never names a fan left unforced
      fr_d = tick && fm_d[slot_d[1:0]];
      tr_d = tick && slot_d == 3'h0 && |tm_q;
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         ecnt_q <= 24'h00_0000; slot_q <= 3'h0; fr_q <= 1'b0; tr_q <= 1'b0;
      end else begin
         ecnt_q <= ecnt_d; slot_q <= slot_d; fr_q <= fr_d; tr_q <= tr_d;
      end
   end

   // A fan under report runs full power during its own slot, so tach is valid
   for (genvar g = 0; g < 4; g++) begin : g_fan
      assign O_FAN_PWR[g] = (fm_q[g] && slot_q[1:0] == 2'(g))
                            ? `LFS_PWR_MAX : set_q.fan_pwr[g];
   end

   assign O_REQ_READY    = (st_q == ST_IDLE);
   assign O_RSP_VALID    = (st_q == ST_RSP);
   assign O_RSP          = rsp_q;
   assign O_LCD_RD_VALID = (st_q == ST_LCD);
   assign O_LCD_ADDR     = req_q.data[0];
   assign O_BUS_OP_VALID = (st_q == ST_BUS);
   assign O_BUS_OP       = op_q;
   assign O_BUS_WDATA    = wd_q;
   assign O_ENUM_START   = es_q;
   assign O_SET          = set_q;
   assign O_BOOT_SET     = boot_q;
   assign O_FAN_RPT      = fr_q;
   assign O_FAN_RPT_IDX  = slot_q[1:0];
   assign O_TEMP_RPT     = tr_q;
   assign O_TEMP_MASK    = tm_q;

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   wire take = I_REQ_VALID && O_REQ_READY;
   a_ack_type: assert property (
      take && I_REQ.typ == `LFS_CMD_CURSTY && I_REQ.len == 5'h01 && I_REQ.data[0] < 8'h04
      |=> O_RSP_VALID && O_RSP.typ == 8'h4C && O_RSP.len == 5'h00)
      else $error("style ack wrong");
   a_contrast_set: assert property (
      take && I_REQ.typ == `LFS_CMD_CONTRAST && I_REQ.len == 5'h01 && I_REQ.data[0] <= 8'h32
      |=> O_RSP_VALID && O_SET.contrast == $past(I_REQ.data[0]) && O_RSP.typ == 8'h4D)
      else $error("contrast not applied");
   a_bad_refused: assert property (
      take && I_REQ.typ == `LFS_CMD_CONTRAST
      && I_REQ.data[0] > 8'h32 |=> $stable(O_SET) && O_RSP.typ == 8'hCD)
      else $error("bad contrast accepted");
   a_cursor_set: assert property (
      take && I_REQ.typ == `LFS_CMD_CURPOS && I_REQ.len == 5'h02
      && I_REQ.data[0] < 8'h10 && I_REQ.data[1] < 8'h02
      |=> O_SET.col == $past(I_REQ.data[0][3:0]) && O_RSP.typ == 8'h4B)
      else $error("cursor not placed");
   a_fan_force: assert property (O_FAN_RPT |-> O_FAN_PWR[O_FAN_RPT_IDX] == 8'h64)
      else $error("reported fan not forced");
   a_fan_report: assert property (O_FAN_RPT |-> fm_q[O_FAN_RPT_IDX] ##1 !O_FAN_RPT)
      else $error("fan report for disabled fan");
   a_info_len: assert property (
      O_RSP_VALID && (O_RSP.typ == 8'h52 || O_RSP.typ == 8'h4A)
      |-> O_RSP.len == 5'h09)
      else $error("data answer length wrong");
   a_save_boot: assert property (I_SAVE_REQ |=> O_BOOT_SET == $past(O_SET))
      else $error("boot state not saved");
   a_bus_order: assert property (
      $rose(st_q == ST_ISSUE) && cnt_q == 6'h00
      |=> O_BUS_OP_VALID && O_BUS_OP == OP_RESET)
      else $error("bus transaction not opened by reset");
endmodule

// *** lfsch_peer.sv ***
// Purpose: far-side model of the LCD reader, sensor bus engine and enumerator
// Assumes: the handler keeps one operation open at a time
// Notes:   every finished bus op is logged as {op, byte} for the bench
`timescale 1ns/10ps
module lfsch_peer import lfsch_pkg::*; #(
   parameter logic [7:0] FAMILY = 8'h5A // Arbitrary family code
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_lcd_v,
   input  wire logic [7:0] i_lcd_a,
   output logic            o_lcd_done = 1'b0,
   output logic [7:0][7:0] o_lcd_d,
   input  wire logic       i_op_v,
   input  wire lfsch_op_e  i_op,
   input  wire logic [7:0] i_wd,
   output logic            o_done = 1'b0,
   output logic [7:0]      o_rd,
   input  wire logic       i_enum_start,
   output logic            o_enum_v = 1'b0,
   output logic [4:0]      o_enum_idx,
   output logic [7:0][7:0] o_enum_code
);
   logic [9:0] log_q[$];
   logic [7:0] rd_n   = 8'h00;
   logic [7:0] rbyte  = 8'h00;
   int         wait_n = 0;
   // One node at index 3; code byte k is k, apart from the family code
   assign o_enum_idx  = 5'h03;
   assign o_enum_code = {56'h07_0605_0403_0201, FAMILY};
   // Data is valid only with its strobe; otherwise the inverse, so stale values never match
   assign o_rd = o_done ? rbyte : ~rbyte;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         o_lcd_d[i] = o_lcd_done ? i_lcd_a + 8'(i) : ~(i_lcd_a + 8'(i));
      end
   end
   // Random latency of 0 to 3 cycles before each strobe, so slow answers get exercised
   always @(posedge i_clk) begin
      o_done     <= 1'b0;
      o_lcd_done <= 1'b0;
      o_enum_v   <= i_enum_start && !i_rst;
      if (i_rst) begin
         rd_n   <= 8'h00;
         wait_n <= 0;
      end else if ((i_op_v && !o_done) || (i_lcd_v && !o_lcd_done)) begin
         if (wait_n > 0) begin
            wait_n <= wait_n - 1;
         end else begin
            wait_n     <= $urandom_range(3, 0);
            o_done     <= i_op_v;
            o_lcd_done <= i_lcd_v;
            if (i_op_v) log_q.push_back({i_op, i_wd});
            if (i_op_v && i_op == OP_READ) begin
               rbyte <= 8'h30 + rd_n; // Read bytes count up from 0x30
               rd_n  <= rd_n + 8'h01;
            end
         end
      end
   end
endmodule

// *** lfsch_top_test.sv ***
// Purpose: self-checking bench of the host command handler
// Assumes: one sensor node at index 3, short report slots
// Notes:   settings are predicted by a small model and compared after every setting command's answer
`timescale 1ns/10ps
module lfsch_top_test import lfsch_pkg::*; ;
   localparam int         EC  = 16;    // Short slot keeps the report run brief
   localparam logic [7:0] FAM = 8'h5A; // Arbitrary family code
   logic            clk = 1'b0, rst = 1'b1, req_v = 1'b0, rsp_r = 1'b0, save = 1'b0;
   logic            watch = 1'b0, rdy, rsp_v, lcd_v, lcd_dn, op_v, done, en_s, en_v, frpt, trpt;
   lfsch_pkt_s      req = '0, rsp_o, rsp;
   logic [7:0]      lcd_a, wd, rd;
   logic [7:0][7:0] lcd_d, en_c;
   logic [4:0]      en_i;
   lfsch_op_e       op;
   lfsch_set_s      set, boot, es, bs;
   logic [3:0][7:0] pwr;
   logic [1:0]      fidx;
   logic [31:0]     tmask, etm;
   int              num_errors = 0, n_compared = 0, nrd = 0, tr = 0, fr[4], fc[4];
   lfsch_top #(.EIGHTH_CYC(EC)) DUT (
      .I_CLK(clk), .I_RST(rst), .I_REQ_VALID(req_v), .I_REQ(req), .O_REQ_READY(rdy),
      .O_RSP_VALID(rsp_v), .O_RSP(rsp_o), .I_RSP_READY(rsp_r), .O_LCD_RD_VALID(lcd_v),
      .O_LCD_ADDR(lcd_a), .I_LCD_RD_DONE(lcd_dn), .I_LCD_RD_DATA(lcd_d),
      .O_BUS_OP_VALID(op_v), .O_BUS_OP(op), .O_BUS_WDATA(wd), .I_BUS_DONE(done),
      .I_BUS_RDATA(rd), .O_ENUM_START(en_s), .I_ENUM_VALID(en_v), .I_ENUM_IDX(en_i),
      .I_ENUM_CODE(en_c), .O_SET(set), .O_FAN_PWR(pwr), .I_SAVE_REQ(save),
      .O_BOOT_SET(boot), .O_FAN_RPT(frpt), .O_FAN_RPT_IDX(fidx), .O_TEMP_RPT(trpt),
      .O_TEMP_MASK(tmask));
   lfsch_peer #(.FAMILY(FAM)) peer (
      .i_clk(clk), .i_rst(rst), .i_lcd_v(lcd_v), .i_lcd_a(lcd_a), .o_lcd_done(lcd_dn),
      .o_lcd_d(lcd_d), .i_op_v(op_v), .i_op(op), .i_wd(wd), .o_done(done), .o_rd(rd),
      .i_enum_start(en_s), .o_enum_v(en_v), .o_enum_idx(en_i), .o_enum_code(en_c));
   // 125 MHz clock
   initial begin
      forever #4 clk = ~clk;
   end
   // Host takes answers on three cycles out of four, so answers must stand while stalled
   always @(posedge clk) rsp_r <= ($urandom % 4) != 0;
   // Report pulses and forced fan power are counted only inside the watch window
   always @(negedge clk) begin
      if (watch && frpt === 1'b1) fr[fidx]++;
      if (watch && trpt === 1'b1) tr++;
      for (int j = 0; j < 4; j++) if (watch && pwr[j] === 8'h64) fc[j]++;
   end
   task automatic chk(input logic [127:0] g, input logic [127:0] e, input string m);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t %s got %0h exp %0h", $time, m, g, e);
      end
   endtask
   // One request, held until taken, then the answer captured at the falling edge just before the edge that takes it
   task automatic send(input logic [7:0] t, input int n, input lfsch_bytes_t d);
      int k;
      @(posedge clk);
      req_v <= 1'b1;
      req   <= '{typ: t, len: 5'(n), data: d};
      k = 0;
      do @(negedge clk); while (rdy !== 1'b1 && k++ < 1000);
      @(posedge clk);
      req_v    <= 1'b0;
      req.data <= ~d;
      k = 0;
      do @(negedge clk); while (!(rsp_v === 1'b1 && rsp_r) && k++ < 1000);
      rsp = rsp_o;
      chk(k < 1000, 1, "answer wait");
      @(posedge clk);
   endtask
   // Setting commands: predicted answer type, then O_SET and the temperature mask against the model
   task automatic cmd(input logic [7:0] t, input int n, input lfsch_bytes_t d);
      bit ok;
      case (t)
         8'h0B:   ok = n == 2 && d[0] < 16 && d[1] < 2;
         8'h0C:   ok = n == 1 && d[0] < 4;
         8'h0D:   ok = n == 1 && d[0] <= 50;
         8'h0E:   ok = n == 1 && d[0] <= 100;
         8'h10:   ok = n == 1 && d[0] <= 15;
         8'h11:   ok = n == 4 && d[0] <= 100 && d[1] <= 100 && d[2] <= 100 && d[3] <= 100;
         default: ok = n == 4;
      endcase
      send(t, n, d);
      if (ok && t == 8'h0B) es.col = d[0][3:0];
      if (ok && t == 8'h0B) es.row = d[1][0];
      if (ok && t == 8'h0C) es.style = d[0][1:0];
      if (ok && t == 8'h0D) es.contrast = d[0];
      if (ok && t == 8'h0E) es.backlight = d[0];
      if (ok && t == 8'h11) es.fan_pwr = d[3:0];
      if (ok && t == 8'h13) etm = d[3:0];
      chk({rsp.typ, 3'h0, rsp.len}, {t | (ok ? 8'h40 : 8'hC0), 8'h00}, "ack");
      chk(set, es, "settings");
      chk(tmask, etm, "temp mask");
   endtask
   // Bus transaction: predicted op log and read bytes
   task automatic bus(input logic [7:0] idx, input int nw, input int nr);
      lfsch_bytes_t d;
      logic [9:0]   ex[$];
      bit           ok;
      ok = (idx == 8'h20 || idx == 8'h03) && nr <= 16;
      d = '0;
      d[0] = idx;
      d[1] = 8'(nr);
      if (ok) ex.push_back({OP_RESET, 8'h00});
      for (int k = 0; k < 9 && ok && idx < 8'h20; k++) begin
         ex.push_back({OP_WRITE, k == 0 ? 8'h55 : k == 1 ? FAM : 8'(k - 1)});
      end
      for (int k = 0; k < nw; k++) begin
         d[k + 2] = 8'($urandom);
         if (ok) ex.push_back({OP_WRITE, d[k + 2]});
      end
      for (int k = 0; k < nr && ok; k++) ex.push_back({OP_READ, 8'h00});
      peer.log_q.delete();
      send(8'h14, nw + 2, d);
      chk({rsp.typ, 3'h0, rsp.len}, {ok ? 8'h54 : 8'hD4, 8'(ok ? nr : 0)}, "bus ack");
      for (int k = 0; k < nr && ok; k++) chk(rsp.data[k], 8'h30 + 8'(nrd + k), "rd");
      if (ok) nrd += nr;
      chk(peer.log_q.size(), ex.size(), "op count");
      foreach (ex[k]) chk(peer.log_q[k] & (ex[k][9:8] == 2'h1 ? 10'h3FF : 10'h300), ex[k], "op");
   endtask
   task automatic results;
      $display("Compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watchdog well beyond the thousand or so cycles the sequence needs
   initial begin
      repeat (30000) @(posedge clk);
      chk(0, 1, "timeout");
      results();
   end
   initial begin
      lfsch_bytes_t d;
      logic [7:0]   tl[7] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h13};
      int           gl[7] = '{2, 1, 1, 1, 1, 4, 4};
      int           n;
      void'($urandom(32'hae3b));
      es = '{col: 4'h0, row: 1'b0, style: 2'h0, contrast: 8'h10, backlight: 8'h64,
             fan_pwr: {4{8'h64}}};
      etm = '0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      // Reset values, then exactly one enumeration pulse at the first edge
      @(negedge clk);
      chk({set, en_s}, {es, 1'b0}, "reset");
      @(negedge clk);
      chk(en_s, 1, "enum pulse");
      @(negedge clk);
      chk(en_s, 0, "enum end");
      // Every setting command, with lengths and values partly out of range
      for (int i = 0; i < 84; i++) begin
         for (int j = 0; j < 16; j++) begin
            d[j] = ($urandom % 2) ? 8'($urandom % 16) : 8'($urandom % 128);
         end
         if (tl[i % 7] == 8'h13) d[3:0] = 32'($urandom % 2) << 3; // Only the found node
         n = ($urandom % 5 != 0) ? gl[i % 7] : $urandom % 6;
         cmd(tl[i % 7], n, d);
      end
      // Boot copy is taken on the pulse only, later changes stay out of it
      @(posedge clk);
      save <= 1'b1;
      @(posedge clk);
      save <= 1'b0;
      bs = es;
      d = '0;
      cmd(8'h0D, 1, d);
      chk(boot, bs, "boot");
      // Identity of the found node, then an index out of range
      d[0] = 8'h03;
      send(8'h12, 1, d);
      chk({rsp.typ, 3'h0, rsp.len}, 16'h5209, "info hdr");
      chk(rsp.data[8:0], {56'h07_0605_0403_0201, FAM, 8'h03}, "info");
      d[0] = 8'h2B;
      send(8'h12, 1, d);
      chk({rsp.typ, 3'h0, rsp.len}, 16'hD200, "info bad");
      // Display memory read
      d[0] = 8'h47;
      send(8'h0A, 1, d);
      chk({rsp.typ, 3'h0, rsp.len}, 16'h4A09, "lcd hdr");
      chk(rsp.data[8:0], {64'h4E4D_4C4B_4A49_4847, 8'h47}, "lcd data");
      // Bus transactions, including boundaries and refusals
      bus(8'h20, 3, 2);
      bus(8'h03, 0, 0);
      bus(8'h03, 14, 16);
      bus(8'h05, 0, 1);
      bus(8'h20, 0, 17);
      // Fans 0 and 2 and sensor 3 reported over two full report periods
      d = '0;
      d[3:0] = {4{8'h1E}};
      cmd(8'h11, 4, d);
      d[3:0] = 32'h0000_0005;
      cmd(8'h10, 1, d);
      d[3:0] = 32'h0000_0008;
      cmd(8'h13, 4, d);
      @(posedge clk);
      watch = 1'b1;
      repeat (16 * EC) @(posedge clk);
      watch = 1'b0;
      chk({fr[0], fr[1], fr[2], fr[3]}, {32'd4, 32'd0, 32'd4, 32'd0}, "fan reports");
      chk({fc[0], fc[1], fc[2], fc[3]}, {32'(4 * EC), 32'd0, 32'(4 * EC), 32'd0},
          "forced");
      chk(tr, 2, "temp reports");
      results();
   end
endmodule
